// [rtl/ost_pkg.sv]
// Purpose: shared constants and types for the oscillator switch and self-tune block
// Assumes: plain register port, 16-bit registers, 50 MHz core clock
// Notes:   offsets are register word addresses on the plain port
`default_nettype none
package ost_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0]  OST_ADDR_CTRL_HI  = 4'h0;
  localparam logic [3:0]  OST_ADDR_CTRL_LO  = 4'h1;
  localparam logic [3:0]  OST_ADDR_TRIM     = 4'h2;
  localparam logic [3:0]  OST_ADDR_STATUS   = 4'h3;
  // ==========================================================
  // unlock keys
  localparam logic [7:0]  OST_KEY_HI_A      = 8'h78;
  localparam logic [7:0]  OST_KEY_HI_B      = 8'h9a;
  localparam logic [7:0]  OST_KEY_LO_A      = 8'h46;
  localparam logic [7:0]  OST_KEY_LO_B      = 8'h57;
  // ==========================================================
  // field positions
  localparam int          OST_HI_NSEL_LSB   = 0;
  localparam int          OST_NSEL_W        = 3;
  localparam int          OST_LO_SWREQ_BIT  = 0;
  localparam int          OST_TRIM_EN_BIT   = 15;
  localparam int          OST_TRIM_REF_BIT  = 12;
  localparam int          OST_TRIM_LOCK_BIT = 11;
  localparam int          OST_TRIM_LPOL_BIT = 10;
  localparam int          OST_TRIM_RNG_BIT  = 9;
  localparam int          OST_TRIM_RPOL_BIT = 8;
  localparam int          OST_TUNE_W        = 6;
  // ==========================================================
  // reset values
  localparam logic [15:0] OST_TRIM_RST      = 16'h0000;
  localparam logic [2:0]  OST_NSEL_RST      = 3'h0;
  // ==========================================================
  // self-tune measurement: reference period in core cycles
  localparam int          OST_CORE_MHZ      = 50;
  localparam int          OST_SOF_US        = 1000;
  localparam int          OST_SOF_CYC       = OST_SOF_US * OST_CORE_MHZ;
  // lock window 0.2 %, range window 1.5 %, in tenths of a percent
  localparam int          OST_LOCK_PERMIL   = 2;
  localparam int          OST_RANGE_PERMIL  = 15;
  // ==========================================================
  // measurement result carried from counter to loop
  typedef struct packed {
    logic        valid;
    logic [23:0] count;
  } ost_meas_t;
  // unlock sequencer states
  typedef enum logic [2:0] {
    OST_LK_IDLE = 3'b001,
    OST_LK_KEY1 = 3'b010,
    OST_LK_OPEN = 3'b100
  } ost_lock_st_t;
endpackage : ost_pkg
`default_nettype wire

// [rtl/ost_unlock.sv]
// Purpose: two-key unlock for one protected control byte
// Assumes: each register write is one instruction
// Notes:   any other write to this byte drops the sequence, except a repeated first key, which restarts it
`default_nettype none
module ost_unlock
  import ost_pkg::*;
#(
  parameter logic [7:0] KEY_A = 8'h00,
  parameter logic [7:0] KEY_B = 8'h00
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_wr,        // write to this byte
  input  wire logic       i_wr_other,  // write to any other register
  input  wire logic [7:0] i_data,
  output logic            o_open       // next write here is accepted
);
  ost_lock_st_t st_q;
  // ==========================================================
  // sequencer: any stray write between keys re-locks, except a repeated first key, which stays in KEY1
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      st_q <= OST_LK_IDLE;
    else if (i_ce)
    begin
      unique case (st_q)
        OST_LK_IDLE:
          if (i_wr && i_data == KEY_A)
            st_q <= OST_LK_KEY1;
        OST_LK_KEY1:
          if (i_wr && i_data == KEY_B)
            st_q <= OST_LK_OPEN;
          else if (i_wr || i_wr_other)
            st_q <= (i_wr && i_data == KEY_A) ? OST_LK_KEY1 : OST_LK_IDLE;
        OST_LK_OPEN:
          if (i_wr || i_wr_other)
            st_q <= OST_LK_IDLE;  // one protected write only
        default:
          st_q <= OST_LK_IDLE;
      endcase
    end
  end
  assign o_open = (st_q == OST_LK_OPEN);
endmodule : ost_unlock
`default_nettype wire

// [rtl/ost_top.sv]
// Purpose: protected clock-source switch and internal RC self-tune loop
// Assumes: i_ref_tick pulses once per reference period, synchronous to i_core_clk
// Notes:   trim loop counts rc ticks per reference period and steps the trim by one
//
// Functional notes
// - high control byte opens only after keys 78h then 9Ah back to back
// - source selection write must directly follow high unlock; it becomes pending
// - low control byte opens only after keys 46h then 57h back to back
// - switch request set right after low unlock starts switching to pending source
// - request bit clears on success; lock status shows failure cause otherwise
// - trim bit 15 enables automatic calibration of the internal RC oscillator
// - trim bit 12 chooses reference: 1 USB frames, 0 crystal oscillator
// - loop adjusts 6-bit trim field bits 5:0 continuously while running
// - software writes to trim field are ignored while self-tuning
// - loop holds internal RC oscillator close to 8 MHz
// - drift beyond 0.2 percent flags lock loss and may interrupt
// - error beyond 1.5 percent flags out of range and may interrupt
// - lock status in bit 11, range status in bit 9 of trim register
// - polarity bits 10 and 8 pick interrupt on condition present or absent
// - crystal reference tunes only while the crystal oscillator is enabled
`default_nettype none
module ost_top
  import ost_pkg::*;
#(
  parameter int RC_TARGET = 8000 // rc ticks per reference period at 8 MHz
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  // register port
  input  wire logic [3:0]              i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [15:0]             o_rdata,
  // clock switch plant
  input  wire logic                    i_switch_done,  // switcher reports success
  input  wire logic                    i_pll_locked,
  output logic      [OST_NSEL_W-1:0]   o_new_source,
  output logic                         o_switch_req,
  // self-tune plant
  input  wire logic                    i_rc_tick,      // one per rc osc period
  input  wire logic                    i_ref_tick,     // reference period end
  input  wire logic                    i_ref_usb,      // usb frame reference strobe
  input  wire logic                    i_xtal_on,      // crystal oscillator enabled
  output logic      [OST_TUNE_W-1:0]   o_trim,
  output logic                         o_tune_irq
);
  // ==========================================================
  // declarations
  logic                  wr_hi, wr_lo, wr_trim;
  logic                  hi_open, lo_open;
  logic [OST_NSEL_W-1:0] nsel_q;
  logic                  swreq_q;
  logic [15:0]           trim_q;
  logic                  irq_q;
  logic [15:0]           rdata_q;
  logic [23:0]           cnt_q;
  ost_meas_t             meas_q;
  logic                  ref_ev;
  logic                  tune_run;
  logic [23:0]           err_abs;
  logic                  too_slow;
  logic                  lock_bad, range_bad;
  logic                  irq_d;

  assign wr_hi   = i_wr && i_addr == OST_ADDR_CTRL_HI;
  assign wr_lo   = i_wr && i_addr == OST_ADDR_CTRL_LO;
  assign wr_trim = i_wr && i_addr == OST_ADDR_TRIM;

  // ==========================================================
  // unlock sequencers, one per protected byte
  ost_unlock #(
    .KEY_A (OST_KEY_HI_A),
    .KEY_B (OST_KEY_HI_B)
  ) u_unlock_hi (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_wr       (wr_hi),
    .i_wr_other (i_wr && !wr_hi),
    .i_data     (i_wdata[7:0]),
    .o_open     (hi_open)
  );

  ost_unlock #(
    .KEY_A (OST_KEY_LO_A),
    .KEY_B (OST_KEY_LO_B)
  ) u_unlock_lo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_wr       (wr_lo),
    .i_wr_other (i_wr && !wr_lo),
    .i_data     (i_wdata[7:0]),
    .o_open     (lo_open)
  );

  // ==========================================================
  // pending source choice, only in the slot right after unlock
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      nsel_q <= OST_NSEL_RST;
    else if (i_ce && wr_hi && hi_open)
      nsel_q <= i_wdata[OST_HI_NSEL_LSB +: OST_NSEL_W];
  end

  // ==========================================================
  // switch request: set by protected write, cleared by success
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      swreq_q <= 1'b0;
    else if (i_ce)
    begin
      if (wr_lo && lo_open && i_wdata[OST_LO_SWREQ_BIT])
        swreq_q <= 1'b1;
      else if (swreq_q && i_switch_done)
        swreq_q <= 1'b0;
    end
  end

  assign o_new_source = nsel_q;
  assign o_switch_req = swreq_q;

  // ==========================================================
  // reference selection and gating
  assign ref_ev   = trim_q[OST_TRIM_REF_BIT] ? i_ref_usb : (i_ref_tick && i_xtal_on);
  assign tune_run = trim_q[OST_TRIM_EN_BIT] &&
                    (trim_q[OST_TRIM_REF_BIT] || i_xtal_on);

  // ==========================================================
  // rc tick counter per reference period
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cnt_q  <= 24'h00_0000;
      meas_q <= '0;
    end
    else if (i_ce)
    begin
      meas_q.valid <= 1'b0;
      if (!tune_run)
        cnt_q <= 24'h00_0000;
      else if (ref_ev)
      begin
        meas_q.valid <= 1'b1;
        meas_q.count <= cnt_q + {23'h00_0000, i_rc_tick};
        cnt_q        <= 24'h00_0000;
      end
      else if (i_rc_tick)
        cnt_q <= cnt_q + 24'h00_0001;
    end
  end

  // ==========================================================
  // error against 8 MHz target, as absolute ticks
  assign too_slow = meas_q.count < 24'(RC_TARGET);
  assign err_abs  = too_slow ? 24'(RC_TARGET) - meas_q.count
                             : meas_q.count - 24'(RC_TARGET);
  // thresholds scaled in tenths of a percent; avoids a divider
  assign lock_bad  = (err_abs * 24'd1000) > 24'(RC_TARGET * OST_LOCK_PERMIL);
  assign range_bad = (err_abs * 24'd1000) > 24'(RC_TARGET * OST_RANGE_PERMIL);

  // ==========================================================
  // trim register: hardware loop owns the trim field while running
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      trim_q <= OST_TRIM_RST;
    else if (i_ce)
    begin
      if (wr_trim)
      begin
        trim_q[OST_TRIM_EN_BIT]   <= i_wdata[OST_TRIM_EN_BIT];
        trim_q[OST_TRIM_REF_BIT]  <= i_wdata[OST_TRIM_REF_BIT];
        trim_q[OST_TRIM_LPOL_BIT] <= i_wdata[OST_TRIM_LPOL_BIT];
        trim_q[OST_TRIM_RPOL_BIT] <= i_wdata[OST_TRIM_RPOL_BIT];
        if (!tune_run)
          trim_q[OST_TUNE_W-1:0] <= i_wdata[OST_TUNE_W-1:0];
      end
      if (tune_run && meas_q.valid)
      begin
        trim_q[OST_TRIM_LOCK_BIT] <= !lock_bad;
        trim_q[OST_TRIM_RNG_BIT]  <= range_bad;
        // one step per period; saturates at the field limits
        if (lock_bad && too_slow && trim_q[OST_TUNE_W-1:0] != 6'h3f)
          trim_q[OST_TUNE_W-1:0] <= trim_q[OST_TUNE_W-1:0] + 6'h01;
        else if (lock_bad && !too_slow && trim_q[OST_TUNE_W-1:0] != 6'h00)
          trim_q[OST_TUNE_W-1:0] <= trim_q[OST_TUNE_W-1:0] - 6'h01;
      end
    end
  end

  assign o_trim = trim_q[OST_TUNE_W-1:0];

  // ==========================================================
  // interrupt line: lock loss or out-of-range, each with polarity
  assign irq_d = tune_run &&
                 ((trim_q[OST_TRIM_LOCK_BIT] == trim_q[OST_TRIM_LPOL_BIT]) ||
                  (trim_q[OST_TRIM_RNG_BIT]  != trim_q[OST_TRIM_RPOL_BIT]));

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      irq_q <= 1'b0;
    else if (i_ce)
      irq_q <= irq_d;
  end
  assign o_tune_irq = irq_q;

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      rdata_q <= 16'h0000;
    else if (i_ce)
    begin
      rdata_q <= 16'h0000;
      if (i_rd)
      begin
        unique case (i_addr)
          OST_ADDR_CTRL_HI: rdata_q <= {13'h0000, nsel_q};
          OST_ADDR_CTRL_LO: rdata_q <= {15'h0000, swreq_q};
          OST_ADDR_TRIM:    rdata_q <= trim_q;
          OST_ADDR_STATUS:  rdata_q <= {13'h0000, irq_q, i_pll_locked, swreq_q};
          default:          rdata_q <= 16'h0000;
        endcase
      end
    end
  end
  assign o_rdata = rdata_q;
endmodule : ost_top
`default_nettype wire

// [verification/ost_props.sv]
// Purpose: port-level checker for ost_top
// Assumes: one clock domain, synchronous reset
// Notes:   enable bit mirrored from writes, the run state is not visible
`default_nettype none
module ost_props
  import ost_pkg::*;
#(
  parameter int RC_TARGET = 8000
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_switch_done,
  input wire logic        i_pll_locked,
  input wire logic [2:0]  o_new_source,
  input wire logic        o_switch_req,
  input wire logic        i_rc_tick,
  input wire logic        i_ref_tick,
  input wire logic        i_ref_usb,
  input wire logic        i_xtal_on,
  input wire logic [5:0]  o_trim,
  input wire logic        o_tune_irq
);
  // mirror of the tune enable, needed to know when trim writes count
  logic en_q;
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      en_q <= 1'b0;
    else if (i_ce && i_wr && i_addr == OST_ADDR_TRIM)
      en_q <= i_wdata[OST_TRIM_EN_BIT];
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ====================
  // key sequences
  sequence s_wr(a, d);
    i_ce && i_wr && i_addr == a && i_wdata[7:0] == d;
  endsequence
  sequence s_hi_open;
    s_wr(OST_ADDR_CTRL_HI, OST_KEY_HI_A) ##1 s_wr(OST_ADDR_CTRL_HI, OST_KEY_HI_B);
  endsequence
  sequence s_lo_open;
    s_wr(OST_ADDR_CTRL_LO, OST_KEY_LO_A) ##1 s_wr(OST_ADDR_CTRL_LO, OST_KEY_LO_B);
  endsequence
  // ====================
  // properties
  property p_src_set;
    s_hi_open ##1 (i_ce && i_wr && i_addr == OST_ADDR_CTRL_HI)
      |=> o_new_source == $past(i_wdata[2:0]);
  endproperty
  property p_src_hold;
    $changed(o_new_source) && !$past(i_rst)
      |-> $past(i_ce && i_wr && i_addr == OST_ADDR_CTRL_HI);
  endproperty
  property p_req_set;
    s_lo_open ##1 (i_ce && i_wr && i_addr == OST_ADDR_CTRL_LO && i_wdata[0] && !i_switch_done)
      |=> o_switch_req;
  endproperty
  property p_req_rise;
    $rose(o_switch_req) && !$past(i_rst)
      |-> $past(i_wr && i_addr == OST_ADDR_CTRL_LO && i_wdata[0]);
  endproperty
  property p_req_clr;
    o_switch_req && i_switch_done && i_ce && !i_wr |=> !o_switch_req;
  endproperty
  // only software with tuning off may jump the trim; the loop steps by one
  property p_trim_step;
    $changed(o_trim) && !$past(i_rst) && !$past(i_wr && i_addr == OST_ADDR_TRIM && !en_q)
      |-> o_trim - $past(o_trim) == 6'h01 || $past(o_trim) - o_trim == 6'h01;
  endproperty
  property p_rd_trim;
    $past(i_ce && i_rd && i_addr == OST_ADDR_TRIM) && !$past(i_rst)
      |-> o_rdata[5:0] == $past(o_trim) && o_rdata[15] == $past(en_q);
  endproperty
  property p_irq_off;
    !en_q && !$past(en_q) && !$past(en_q, 2) |-> !o_tune_irq;
  endproperty
  a_src_set: assert property (p_src_set) else $error("source not taken");
  a_src_hold: assert property (p_src_hold) else $error("source moved");
  a_req_set: assert property (p_req_set) else $error("request not set");
  a_req_rise: assert property (p_req_rise) else $error("request set alone");
  a_req_clr: assert property (p_req_clr) else $error("request not cleared");
  a_trim_step: assert property (p_trim_step) else $error("trim jumped");
  a_rd_trim: assert property (p_rd_trim) else $error("trim readback");
  a_irq_off: assert property (p_irq_off) else $error("irq while off");
endmodule : ost_props
bind ost_top ost_props #(.RC_TARGET(RC_TARGET)) u_props (.i_core_clk, .i_rst, .i_ce, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_switch_done, .i_pll_locked, .o_new_source,
  .o_switch_req, .i_rc_tick, .i_ref_tick, .i_ref_usb, .i_xtal_on, .o_trim, .o_tune_irq);
`default_nettype wire

// [verification/tb.sv]
// Purpose: register-level bench for ost_top
// Assumes: rc and reference ticks made here, reference at a fixed rate, rc rate set by rc_div
// Notes:   target cut to 100 ticks, so one reference period is 200 cycles
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ost_pkg::*;
  // ====================
  // signals
  localparam int RCT = 100;
  localparam int REFP = 200;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_switch_done = 1'b0, i_pll_locked = 1'b0, i_rc_tick = 1'b0, i_xtal_on = 1'b1;
  logic i_ref_tick = 1'b0, i_ref_usb = 1'b0, o_switch_req, o_tune_irq;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata, rv;
  logic [2:0]  o_new_source;
  logic [5:0]  o_trim, t1;
  int          bad_count = 0, n_tests = 0, rc_div = 2, rcc = 0, rfc = 0;
  bit          usb_md = 1'b0;
  logic [15:0] pol [3] = '{16'h0000, 16'h0400, 16'h0100};
  logic [19:0] bad_t [4][4] = '{
    '{20'h0_0078, 20'h0_009b, 20'h0_0003, 20'hf_0000},
    '{20'h0_0078, 20'hf_0000, 20'h0_009a, 20'h0_0003},
    '{20'h0_0078, 20'h0_009a, 20'hf_0000, 20'h0_0003},
    '{20'h1_0046, 20'h1_0056, 20'h1_0001, 20'hf_0000}};
  ost_top #(.RC_TARGET(RCT)) dut_u (.i_core_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_switch_done, .i_pll_locked, .o_new_source, .o_switch_req,
    .i_rc_tick, .i_ref_tick, .i_ref_usb, .i_xtal_on, .o_trim, .o_tune_irq);
  // 50 MHz core clock
  initial
  begin
    forever #10 i_core_clk = ~i_core_clk;
  end
  // free-running ticks; rc_div sets how far the rc osc is off target
  always @(posedge i_core_clk)
  begin
    rcc <= (rcc + 1 >= rc_div) ? 0 : rcc + 1;
    rfc <= (rfc == REFP - 1) ? 0 : rfc + 1;
    i_rc_tick <= (rcc == 0);
    i_ref_tick <= !usb_md && (rfc == 0);
    i_ref_usb <= usb_md && (rfc == 0);
  end
  // ====================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // leaves the strobe up so writes can run back to back
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
  endtask : wr_reg
  task automatic waitc(input int n);
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : waitc
  task automatic rd_reg(input logic [3:0] a);
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    rv = o_rdata;
  endtask : rd_reg
  task automatic key3(input logic [3:0] a, input logic [15:0] k1, k2, v);
    wr_reg(a, k1);
    wr_reg(a, k2);
    wr_reg(a, v);
    waitc(0);
  endtask : key3
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // watchdog, about 2.5 times the planned run
  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end
  // ====================
  // main sequence
  initial
  begin
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(negedge i_core_clk);
    chk({o_tune_irq, o_switch_req, o_new_source, o_trim}, 16'h0000);
    rd_reg(OST_ADDR_TRIM);
    chk(rv, OST_TRIM_RST);
    rd_reg(4'hf);
    chk(rv, 16'h0000);
    // clean switch, nothing between keys and protected write
    key3(OST_ADDR_CTRL_HI, 16'h0078, 16'h009a, 16'h0005);
    chk(o_new_source, 16'h0005);
    @(posedge i_core_clk) i_pll_locked <= 1'b1;
    key3(OST_ADDR_CTRL_LO, 16'h0046, 16'h0057, 16'h0001);
    chk(o_switch_req, 16'h0001);
    waitc(20);
    rd_reg(OST_ADDR_STATUS);
    chk(rv[1:0], 16'h0003);
    @(posedge i_core_clk) i_switch_done <= 1'b1;
    @(posedge i_core_clk) i_switch_done <= 1'b0;
    @(negedge i_core_clk);
    chk(o_switch_req, 16'h0000);
    // broken sequences leave both bytes as they were
    for (int r = 0; r < 4; r++)
    begin
      for (int w = 0; w < 4; w++)
        wr_reg(bad_t[r][w][19:16], bad_t[r][w][15:0]);
      waitc(0);
      chk({o_switch_req, o_new_source}, 16'h0005);
    end
    // exact rate: locked, in range, trim steady and write-protected
    wr_reg(OST_ADDR_TRIM, 16'h0020);
    wr_reg(OST_ADDR_TRIM, 16'h8020);
    waitc(4 * REFP);
    rd_reg(OST_ADDR_TRIM);
    t1 = rv[5:0];
    chk({rv[15], rv[11], rv[9], t1[5:2]}, 16'h0068);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(OST_ADDR_TRIM, 16'h8000 | pol[i]);
      waitc(3);
      chk({o_trim, o_tune_irq}, {t1, pol[i] != 16'h0000});
    end
    // slow rc osc: out of range, lock lost, trim climbs
    @(posedge i_core_clk) rc_div <= 3;
    waitc(4 * REFP);
    rd_reg(OST_ADDR_TRIM);
    chk({rv[11], rv[9], rv[5:0] > t1}, 16'h0003);
    chk(o_tune_irq, 16'h0001);
    // crystal off stops tuning; usb frames ignored in crystal mode
    @(posedge i_core_clk) i_xtal_on <= 1'b0;
    @(negedge i_core_clk);
    t1 = o_trim;
    waitc(3 * REFP);
    chk(o_trim, t1);
    @(posedge i_core_clk) usb_md <= 1'b1;
    waitc(3 * REFP);
    chk(o_trim, t1);
    // tuning is idle here (crystal off), so the trim field is writable: keep it
    wr_reg(OST_ADDR_TRIM, 16'h9000 | {10'h000, t1});
    waitc(5 * REFP);
    chk(o_trim > t1, 16'h0001);
    // tuning off: no interrupt, trim writable again
    wr_reg(OST_ADDR_TRIM, 16'h0000);
    wr_reg(OST_ADDR_TRIM, 16'h0011);
    waitc(3);
    chk({o_trim, o_tune_irq}, 16'h0022);
    summarize();
  end
endmodule : tb
`default_nettype wire
